// [rtl/cbsc_parity.sv]
// Even parity generator, one bit per data byte.
// Assumes purely combinational use inside the bus block.
`timescale 1ns/1ps
module cbsc_parity #(
  parameter int BYTES = 8
) (
  // Data in
  input wire logic [BYTES*8-1:0] data,
  // Parity out
  output logic [BYTES-1:0] par
);
  // ************************************************************
  // Per-byte parity
  // ************************************************************
  always_comb begin
    for (int i = 0; i < BYTES; i++) begin
      par[i] = ^data[i*8 +: 8];
    end
  end
endmodule : cbsc_parity

// [rtl/cbsc_pkg.sv]
// Package for the processor bus signal control block.
// Assumes a single pclk domain and an APB register port.
package cbsc_pkg;
  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MC_ADDR = 8'h08;
  localparam logic [7:0] OFS_MC_CTRL = 8'h0c;
  localparam logic [7:0] OFS_WDATA_LO = 8'h10;
  localparam logic [7:0] OFS_WDATA_HI = 8'h14;
  localparam logic [7:0] OFS_RDATA_LO = 8'h18;
  localparam logic [7:0] OFS_RDATA_HI = 8'h1c;
  localparam logic [7:0] OFS_CYCLE = 8'h20;
  // ************************************************************
  // Control register fields
  // ************************************************************
  localparam int CTRL_PFS_LSB = 0;    // Pin function select, 2 bits
  localparam int CTRL_MCEN_BIT = 2;   // Machine check enable
  localparam int CTRL_BPM_LSB = 4;    // Breakpoint match inputs, 4 bits
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // ************************************************************
  // Status register fields
  // ************************************************************
  localparam int ST_INTC_BIT = 0;
  localparam int ST_MCX_BIT = 1;
  localparam int ST_PEND_BIT = 2;
  localparam int ST_BUSY_BIT = 3;
  localparam int ST_HOLD_BIT = 4;
  localparam int ST_PERR_BIT = 5;
  localparam int ST_INQ_BIT = 6;
  // ************************************************************
  // Cycle register fields (write starts a cycle)
  // ************************************************************
  localparam int CYC_WR_BIT = 0;
  localparam int CYC_DC_BIT = 1;
  localparam int CYC_CACHE_BIT = 2;
  localparam int CYC_EXCL_BIT = 3;
  localparam int CYC_ADDR_LSB = 3;
  localparam int DATA_W = 64;
  localparam int BYTES = 8;
endpackage : cbsc_pkg

// [rtl/cbsc_strap.sv]
// Strap catcher: samples a level at the first edge after reset release.
// Assumes the strap input is stable around reset release.
`timescale 1ns/1ps
module cbsc_strap (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Strap level and caught value
  input wire logic strap_in,
  output logic strap_q
);
  logic done_r, done_nxt, val_r, val_nxt;
  // ************************************************************
  // Capture once after release
  // ************************************************************
  always_comb begin
    done_nxt = 1'b1;
    val_nxt = done_r ? val_r : strap_in;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
      val_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
      val_r <= val_nxt;
    end
  end
  assign strap_q = val_r;
endmodule : cbsc_strap

// [rtl/cbsc_top.sv]
// Processor-side bus signal control: strap, debug pins, bus cycle,
// data lanes with parity, bus check capture, write ordering.
// Assumes APB from software and synchronous chipset inputs on pclk.
`timescale 1ns/1ps
// Behaviour
// - Interrupt controller enabled only if strap high when reset releases.
// - Each breakpoint output reflects a match of one debug register.
// - Two lowest pins select breakpoint or perfmon; perfmon after reset.
// - Burst ready sampled only in data, pipelined data, pipelined states.
// - Bus request output driven always, high while a request is pending.
// - Active bus check captures current cycle address and control.
// - Machine check exception only when machine check enable set.
// - Bus check during stop clock raises exception after stop clock ends.
// - Cacheable output marks cacheable reads and burst writebacks, length.
// - Non-cacheable read data never marked cacheable despite cache enable.
// - All bus signals driven and sampled on rising clock edge.
// - Data/code select valid in same clock as address strobe.
// - Data bus 64 lines, byte 0 bits 7..0, byte 7 bits 63..56.
// - Write data driven in data phase; read data captured with ready.
// - Even parity per byte driven with write data.
// - Writes to exclusive/modified lines held while write buffer not empty.
// - Address strobe marks a new valid bus cycle being driven.
module cbsc_top #(
  parameter int DATA_W = 64,
  parameter int ADDR_W = 29
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Strap and debug pins
  input wire logic local_intc_enable_strap,
  output logic [3:0] breakpoint_match_pins,
  input wire logic [1:0] perfmon_events,
  output logic intc_enabled,
  // Bus cycle control
  output logic addr_strobe_n,
  output logic data_code_sel,
  output logic write_read_sel,
  output logic cacheable_cycle_n,
  output logic bus_request_out,
  output logic [ADDR_W-1:0] addr_out,
  input wire logic burst_ready_n,
  input wire logic cache_enable_in_n,
  input wire logic bus_check_n,
  input wire logic stop_clock_n,
  input wire logic external_addr_strobe_n,
  input wire logic ext_write_buffer_empty_n,
  // Data lanes (two-way, oe low drives)
  input wire logic [DATA_W-1:0] data_lines_in,
  output logic [DATA_W-1:0] data_lines_out,
  output logic data_lines_oe_n,
  input wire logic [DATA_W/8-1:0] data_parity_lines_in,
  output logic [DATA_W/8-1:0] data_parity_lines_out,
  output logic data_parity_oe_n,
  // Core-side status
  output logic machine_check_exc,
  output logic read_cacheable
);
  localparam int NB = DATA_W / 8;
  typedef enum logic [1:0] {S_IDLE, S_ADDR, S_DATA} cbsc_state_type;

  // ************************************************************
  // State
  // ************************************************************
  cbsc_state_type st_r, st_nxt;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [3:0] cyc_r, cyc_nxt;         // wr, dc, cache, excl
  logic pend_r, pend_nxt;
  logic hold_r, hold_nxt;
  logic [DATA_W-1:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [ADDR_W-1:0] mca_r, mca_nxt;
  logic [3:0] mcc_r, mcc_nxt;
  logic mcx_r, mcx_nxt, bcp_r, bcp_nxt, perr_r, perr_nxt, inq_r, inq_nxt;
  logic rc_r, rc_nxt;
  logic [31:0] prd_r, prd_nxt;
  logic rdy_r, rdy_nxt, err_r, err_nxt;
  logic [3:0] bp_r, bp_nxt;
  logic strb_r, strb_nxt, oe_r, oe_nxt;
  logic [NB-1:0] wpar, rpar;
  logic strap_q;

  // ************************************************************
  // Parity and strap helpers
  // ************************************************************
  cbsc_parity #(.BYTES(NB)) u_wpar (.data(wd_r), .par(wpar));
  cbsc_parity #(.BYTES(NB)) u_rpar (.data(data_lines_in), .par(rpar));
  cbsc_strap u_strap (.pclk(pclk), .presetn(presetn),
    .strap_in(local_intc_enable_strap), .strap_q(strap_q));

  // APB access phase and decode
  logic acc, wr_acc, go;
  logic [31:0] status;
  assign acc = psel && penable && !rdy_r;
  assign wr_acc = acc && pwrite;
  assign go = wr_acc && paddr == cbsc_pkg::OFS_CYCLE && !pend_r && st_r == S_IDLE;

  always_comb begin
    status = 32'h0000_0000;
    status[cbsc_pkg::ST_INTC_BIT] = strap_q;
    status[cbsc_pkg::ST_MCX_BIT] = mcx_r;
    status[cbsc_pkg::ST_PEND_BIT] = bcp_r;
    status[cbsc_pkg::ST_BUSY_BIT] = pend_r;
    status[cbsc_pkg::ST_HOLD_BIT] = hold_r;
    status[cbsc_pkg::ST_PERR_BIT] = perr_r;
    status[cbsc_pkg::ST_INQ_BIT] = inq_r;
  end

  // ************************************************************
  // Register file next state
  // ************************************************************
  always_comb begin
    ctrl_nxt = ctrl_r;
    wd_nxt = wd_r;
    prd_nxt = prd_r;
    rdy_nxt = acc;
    err_nxt = 1'b0;
    if (acc) begin
      unique case (paddr)
        cbsc_pkg::OFS_CTRL: prd_nxt = ctrl_r;
        cbsc_pkg::OFS_STATUS: prd_nxt = status;
        cbsc_pkg::OFS_MC_ADDR: prd_nxt = 32'(mca_r);
        cbsc_pkg::OFS_MC_CTRL: prd_nxt = {28'h0, mcc_r};
        cbsc_pkg::OFS_WDATA_LO: prd_nxt = wd_r[31:0];
        cbsc_pkg::OFS_WDATA_HI: prd_nxt = wd_r[63:32];
        cbsc_pkg::OFS_RDATA_LO: prd_nxt = rd_r[31:0];
        cbsc_pkg::OFS_RDATA_HI: prd_nxt = rd_r[63:32];
        cbsc_pkg::OFS_CYCLE: prd_nxt = {addr_r, cyc_r[2:0]};
        default: begin
          prd_nxt = 32'h0000_0000;
          err_nxt = 1'b1;
        end
      endcase
      if (pwrite) begin
        prd_nxt = 32'h0000_0000;
        if (paddr == cbsc_pkg::OFS_CTRL) ctrl_nxt = pwdata;
        if (paddr == cbsc_pkg::OFS_WDATA_LO && !pend_r) wd_nxt[31:0] = pwdata;
        if (paddr == cbsc_pkg::OFS_WDATA_HI && !pend_r) wd_nxt[63:32] = pwdata;
        if (paddr == cbsc_pkg::OFS_CYCLE && (pend_r || st_r != S_IDLE)) err_nxt = 1'b1;
        if (paddr == cbsc_pkg::OFS_STATUS) err_nxt = 1'b0;
      end
    end
  end

  // ************************************************************
  // Bus cycle sequencer
  // ************************************************************
  logic hold_now, rdy_in;
  assign rdy_in = !burst_ready_n;
  // Held write: exclusive/modified write while external buffer not empty
  assign hold_now = cyc_r[cbsc_pkg::CYC_WR_BIT] && cyc_r[cbsc_pkg::CYC_EXCL_BIT]
                    && ext_write_buffer_empty_n;

  always_comb begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    cyc_nxt = cyc_r;
    pend_nxt = pend_r;
    hold_nxt = hold_now && pend_r && st_r == S_IDLE;
    rd_nxt = rd_r;
    rc_nxt = rc_r;
    perr_nxt = perr_r;
    strb_nxt = 1'b0;
    oe_nxt = 1'b0;
    if (go) begin
      addr_nxt = pwdata[cbsc_pkg::CYC_ADDR_LSB +: ADDR_W];
      cyc_nxt = pwdata[3:0];
      pend_nxt = 1'b1;
    end
    unique case (st_r)
      S_IDLE: if (pend_r && !hold_now) begin
        st_nxt = S_ADDR;
        strb_nxt = 1'b1;
      end
      S_ADDR: begin
        st_nxt = S_DATA;
        oe_nxt = cyc_r[cbsc_pkg::CYC_WR_BIT];
      end
      S_DATA: begin
        oe_nxt = cyc_r[cbsc_pkg::CYC_WR_BIT];
        if (rdy_in) begin
          st_nxt = S_IDLE;
          pend_nxt = 1'b0;
          oe_nxt = 1'b0;
          if (!cyc_r[cbsc_pkg::CYC_WR_BIT]) begin
            rd_nxt = data_lines_in;
            perr_nxt = rpar != data_parity_lines_in;
            // Cache only when cycle cacheable and chipset agrees
            rc_nxt = cyc_r[cbsc_pkg::CYC_CACHE_BIT] && !cache_enable_in_n;
          end
        end
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  // ************************************************************
  // Bus check capture and machine check
  // ************************************************************
  always_comb begin
    mca_nxt = mca_r;
    mcc_nxt = mcc_r;
    bcp_nxt = bcp_r;
    mcx_nxt = 1'b0;
    inq_nxt = inq_r || !external_addr_strobe_n;
    if (acc && pwrite && paddr == cbsc_pkg::OFS_STATUS && pwdata[cbsc_pkg::ST_INQ_BIT])
      inq_nxt = !external_addr_strobe_n;
    if (!bus_check_n) begin
      mca_nxt = addr_r;
      mcc_nxt = cyc_r;
      bcp_nxt = 1'b1;
    end
    // Exception waits for stop clock release
    if (bcp_r && stop_clock_n) begin
      bcp_nxt = !bus_check_n;
      mcx_nxt = ctrl_r[cbsc_pkg::CTRL_MCEN_BIT];
    end
    // Breakpoint or perfmon on the two low pins
    bp_nxt = ctrl_r[cbsc_pkg::CTRL_BPM_LSB +: 4];
    for (int i = 0; i < 2; i++)
      if (!ctrl_r[cbsc_pkg::CTRL_PFS_LSB + i]) bp_nxt[i] = perfmon_events[i];
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= S_IDLE;
      ctrl_r <= cbsc_pkg::CTRL_RST;
      addr_r <= '0;
      cyc_r <= 4'h0;
      pend_r <= 1'b0;
      hold_r <= 1'b0;
      wd_r <= '0;
      rd_r <= '0;
      mca_r <= '0;
      mcc_r <= 4'h0;
      mcx_r <= 1'b0;
      bcp_r <= 1'b0;
      perr_r <= 1'b0;
      inq_r <= 1'b0;
      rc_r <= 1'b0;
      prd_r <= 32'h0000_0000;
      rdy_r <= 1'b0;
      err_r <= 1'b0;
      bp_r <= 4'h0;
      strb_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ctrl_r <= ctrl_nxt;
      addr_r <= addr_nxt;
      cyc_r <= cyc_nxt;
      pend_r <= pend_nxt;
      hold_r <= hold_nxt;
      wd_r <= wd_nxt;
      rd_r <= rd_nxt;
      mca_r <= mca_nxt;
      mcc_r <= mcc_nxt;
      mcx_r <= mcx_nxt;
      bcp_r <= bcp_nxt;
      perr_r <= perr_nxt;
      inq_r <= inq_nxt;
      rc_r <= rc_nxt;
      prd_r <= prd_nxt;
      rdy_r <= rdy_nxt;
      err_r <= err_nxt;
      bp_r <= bp_nxt;
      strb_r <= strb_nxt;
      oe_r <= oe_nxt;
    end
  end

  // ************************************************************
  // Outputs, all from flip-flops except write parity, an XOR of wd_r
  // ************************************************************
  assign prdata = prd_r;
  assign pready = rdy_r;
  assign pslverr = err_r;
  assign breakpoint_match_pins = bp_r;
  assign intc_enabled = strap_q;
  assign addr_strobe_n = !strb_r;
  assign data_code_sel = cyc_r[cbsc_pkg::CYC_DC_BIT];
  assign write_read_sel = cyc_r[cbsc_pkg::CYC_WR_BIT];
  assign cacheable_cycle_n = !cyc_r[cbsc_pkg::CYC_CACHE_BIT];
  assign bus_request_out = pend_r;
  assign addr_out = addr_r;
  assign data_lines_out = wd_r;
  assign data_lines_oe_n = !oe_r;
  assign data_parity_lines_out = wpar;
  assign data_parity_oe_n = !oe_r;
  assign machine_check_exc = mcx_r;
  assign read_cacheable = rc_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  a_strobe_then_data: assert property (@(posedge pclk) disable iff (!presetn)
    !addr_strobe_n |=> st_r == S_DATA) else $error("strobe not followed by data");
  a_ready_ends_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == S_DATA && !burst_ready_n |=> !bus_request_out)
    else $error("ready did not end cycle");
  a_ready_ignored_idle: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == S_IDLE && !pend_r |=> st_r == S_IDLE) else $error("idle left");
  a_write_drive: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == S_DATA && write_read_sel |-> !data_lines_oe_n) else $error("write not driven");
  a_read_float: assert property (@(posedge pclk) disable iff (!presetn)
    !write_read_sel |-> data_lines_oe_n) else $error("read drives lines");
  a_parity_even: assert property (@(posedge pclk) disable iff (!presetn)
    !data_parity_oe_n |-> data_parity_lines_out[NB-1] == ^data_lines_out[DATA_W-1 -: 8])
    else $error("parity wrong");
  a_mcx_gate: assert property (@(posedge pclk) disable iff (!presetn)
    machine_check_exc |-> $past(ctrl_r[cbsc_pkg::CTRL_MCEN_BIT]) && $past(stop_clock_n))
    else $error("exception without enable");
  a_check_capture: assert property (@(posedge pclk) disable iff (!presetn)
    !bus_check_n |=> mca_r == $past(addr_r)) else $error("bus check not captured");
  a_nocache_read: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(read_cacheable) |-> !cacheable_cycle_n) else $error("uncached read cached");
  a_hold_write: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == S_IDLE && hold_now |=> addr_strobe_n) else $error("held write issued");
  a_perfmon_reset: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_r[1:0] == 2'b00 |=> breakpoint_match_pins[1:0] == $past(perfmon_events))
    else $error("perfmon not selected");
endmodule : cbsc_top

// [test/cbsc_chipset_model.sv]
// Chipset model: ends each device cycle with burst ready and read data.
// Assumes one device cycle at a time, all lines moved on rising pclk.
`timescale 1ns/1ps
module cbsc_chipset_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Device cycle start
  input wire logic addr_strobe_n,
  // Bench controls: wait, read data, parity fault
  input wire logic [3:0] dly,
  input wire logic [63:0] rdat,
  input wire logic bad_par,
  // Answers
  output logic burst_ready_n,
  output logic [63:0] data_lines_in,
  output logic [7:0] data_parity_lines_in
);
  // ************************************************************
  // Parity and answer loop
  // ************************************************************
  // Even parity, bit k over byte k
  function automatic logic [7:0] even_par(input logic [63:0] d);
    logic [7:0] p;
    for (int k = 0; k < 8; k++) p[k] = ^d[8*k +: 8];
    return p;
  endfunction : even_par

  // Ready after a chosen wait; released lines show inverted data
  initial begin
    burst_ready_n = 1'b1;
    data_lines_in = 64'h0;
    data_parity_lines_in = 8'hff;
    forever begin
      @(posedge pclk);
      if (presetn === 1'b1 && addr_strobe_n === 1'b0) begin
        repeat (dly) @(posedge pclk);
        burst_ready_n <= 1'b0;
        data_lines_in <= rdat;
        data_parity_lines_in <= even_par(rdat) ^ {7'h0, bad_par};
        @(posedge pclk);
        burst_ready_n <= 1'b1;
        data_lines_in <= ~rdat;
        data_parity_lines_in <= ~even_par(rdat);
      end
    end
  end
endmodule : cbsc_chipset_model

// [test/tb_cpu_bus_signal_control.sv]
// Testbench: APB master, pin stimulus and self checks of the bus block.
// Assumes cbsc_top, its package and the chipset model are compiled first.
`timescale 1ns/1ps
module tb_cpu_bus_signal_control;
  // Clock, reset, APB
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, cv;
  logic [31:0] pwdata, prdata, rd;
  // Pins and expectations
  logic strap, ce_n, bc_n, sc_n, xa_n, wbe_n, bad_par, intc, as_n, dc, wr, cc_n, req;
  logic oe_n, poe_n, mcx, rc, rdy_n, e_wr, e_dc, e_cc;
  logic [1:0] pm;
  logic [3:0] bp, dly;
  logic [28:0] addr, e_addr;
  logic [63:0] din, dout, rdat, wdat, m_d;
  logic [7:0] pin, pout, m_p;
  int miscompares, checks, mcx_cnt, strobes, i, n0;

  // Wire levels of the two-way lanes
  assign din = oe_n ? m_d : dout;
  assign pin = poe_n ? m_p : pout;

  cbsc_top u_cbsc_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .local_intc_enable_strap(strap), .breakpoint_match_pins(bp), .perfmon_events(pm),
    .intc_enabled(intc), .addr_strobe_n(as_n), .data_code_sel(dc), .write_read_sel(wr),
    .cacheable_cycle_n(cc_n), .bus_request_out(req), .addr_out(addr),
    .burst_ready_n(rdy_n), .cache_enable_in_n(ce_n), .bus_check_n(bc_n),
    .stop_clock_n(sc_n), .external_addr_strobe_n(xa_n), .ext_write_buffer_empty_n(wbe_n),
    .data_lines_in(din), .data_lines_out(dout), .data_lines_oe_n(oe_n),
    .data_parity_lines_in(pin), .data_parity_lines_out(pout), .data_parity_oe_n(poe_n),
    .machine_check_exc(mcx), .read_cacheable(rc)
  );

  cbsc_chipset_model u_cbsc_chipset_model (
    .pclk(pclk), .presetn(presetn), .addr_strobe_n(as_n), .dly(dly), .rdat(rdat),
    .bad_par(bad_par), .burst_ready_n(rdy_n), .data_lines_in(m_d), .data_parity_lines_in(m_p)
  );

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report;
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One bus cycle; h means it must wait for the write buffer
  task automatic cyc(input logic w, input logic c, input logic [28:0] a, input logic h);
    int n;
    int s0;
    e_wr = w;
    e_cc = c;
    e_addr = a;
    e_dc = 1'($urandom);
    s0 = strobes;
    apb(1'b1, cbsc_pkg::OFS_CYCLE, {a, c, e_dc, w});
    if (h) begin
      repeat (8) @(posedge pclk);
      apb(1'b0, cbsc_pkg::OFS_STATUS, 32'h0);
      chk({rd[cbsc_pkg::ST_HOLD_BIT], 32'(strobes - s0)}, 33'h1_0000_0000);
      wbe_n <= 1'b0;
    end
    n = 0;
    do begin
      apb(1'b0, cbsc_pkg::OFS_STATUS, 32'h0);
      n++;
    end while (rd[cbsc_pkg::ST_BUSY_BIT] !== 1'b0 && n < 50);
    if (rd[cbsc_pkg::ST_BUSY_BIT] !== 1'b0) miscompares++;
    chk({req, 32'(strobes - s0)}, 33'h1);
  endtask : cyc

  // Cycle outputs at the strobe, lanes while driven, exception pulses
  always @(posedge pclk) begin
    if (presetn && as_n === 1'b0) begin
      strobes++;
      chk(dc, e_dc);
      chk({wr, cc_n, addr, req}, {e_wr, !e_cc, e_addr, 1'b1});
    end
    if (presetn && oe_n === 1'b0) begin
      chk(dout, wdat);
      chk({poe_n, pout, e_wr}, {1'b0, u_cbsc_chipset_model.even_par(wdat), 1'b1});
    end
    if (mcx === 1'b1)
      mcx_cnt++;
  end

  // Clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Watchdog
  initial begin
    #500000;
    miscompares++;
    final_report();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, bad_par, dly, rdat, wdat} = '0;
    {strap, bc_n, sc_n, xa_n, wbe_n, ce_n, pm} = 8'hf2;
    {miscompares, checks, mcx_cnt, strobes} = '0;
    {e_wr, e_dc, e_cc, e_addr, cv, err, rd} = '0;
    rd = $urandom(30214);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    strap <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({intc, bp, cc_n, as_n, oe_n, req}, {1'b1, 2'b00, pm, 4'he});
    apb(1'b0, cbsc_pkg::OFS_CTRL, 32'h0);
    chk(rd, cbsc_pkg::CTRL_RST);
    // Pin function select and breakpoint matches
    for (i = 0; i < 6; i++) begin
      cv = (i == 0) ? 8'hf3 : (i == 1) ? 8'hf0 : 8'($urandom) & 8'hf3;
      apb(1'b1, cbsc_pkg::OFS_CTRL, {24'h0, cv});
      pm <= 2'($urandom);
      repeat (3) @(posedge pclk);
      chk(bp, {cv[7:6], cv[1] ? cv[5] : pm[1], cv[0] ? cv[4] : pm[0]});
    end
    // Writes, the last one exclusive behind a full write buffer
    for (i = 0; i < 4; i++) begin
      wdat = {$urandom, $urandom};
      apb(1'b1, cbsc_pkg::OFS_WDATA_LO, wdat[31:0]);
      apb(1'b1, cbsc_pkg::OFS_WDATA_HI, wdat[63:32]);
      dly <= 4'(i * 3);
      wbe_n <= (i >= 2);
      cyc(1'b1, i[0], {28'($urandom), i == 3}, i == 3);
    end
    // Reads with cacheability, cache enable and a parity fault
    for (i = 0; i < 5; i++) begin
      rdat <= {$urandom, $urandom};
      ce_n <= i[1];
      bad_par <= (i == 4);
      dly <= 4'(7 - i);
      cyc(1'b0, i[0], 29'($urandom), 1'b0);
      apb(1'b0, cbsc_pkg::OFS_RDATA_LO, 32'h0);
      chk(rd, rdat[31:0]);
      apb(1'b0, cbsc_pkg::OFS_RDATA_HI, 32'h0);
      chk(rd, rdat[63:32]);
      apb(1'b0, cbsc_pkg::OFS_STATUS, 32'h0);
      chk({rd[cbsc_pkg::ST_PERR_BIT], rc}, {i == 4, i[0] & ~i[1]});
    end
    // Bus check: enabled, during stop clock, disabled
    for (i = 0; i < 3; i++) begin
      apb(1'b1, cbsc_pkg::OFS_CTRL, (i == 2) ? 32'h0 : 32'h4);
      sc_n <= (i != 1);
      n0 = mcx_cnt;
      bc_n <= 1'b0;
      @(posedge pclk);
      bc_n <= 1'b1;
      repeat (6) @(posedge pclk);
      chk(mcx_cnt - n0, i == 0);
      sc_n <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(mcx_cnt - n0, i != 2);
      apb(1'b0, cbsc_pkg::OFS_MC_ADDR, 32'h0);
      chk(rd[28:0], e_addr);
      apb(1'b0, cbsc_pkg::OFS_MC_CTRL, 32'h0);
      chk(rd[3:0], {e_addr[0], e_cc, e_dc, e_wr});
    end
    // Inquire strobe seen, then cleared
    xa_n <= 1'b0;
    @(posedge pclk);
    xa_n <= 1'b1;
    apb(1'b0, cbsc_pkg::OFS_STATUS, 32'h0);
    chk(rd[cbsc_pkg::ST_INQ_BIT], 1'b1);
    apb(1'b1, cbsc_pkg::OFS_STATUS, 32'h40);
    apb(1'b0, cbsc_pkg::OFS_STATUS, 32'h0);
    chk(rd[cbsc_pkg::ST_INQ_BIT], 1'b0);
    // Unmapped address refused
    apb(1'b0, 8'h24, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    final_report();
  end
endmodule : tb_cpu_bus_signal_control
